// file: rtl/tpcc_pkg.sv
/*
 * Package for the timer pair common control block: register map, field layout,
 * reset values, combine and edge codes, glitch widths and the bus carrier struct.
 * Assumes a single 100 MHz clock and a classic Wishbone register bus.
 */
package tpcc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_INDEX   = 8'h01;
    localparam logic [7:0] CTRL_ADDR    = 8'h04;
    localparam logic [7:0] CTRL_RESET   = 8'h00;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int BIT_LEVEL_FLAG = 0;
    localparam int BIT_SELECT     = 1;
    localparam int LSB_LOGIC      = 2;
    localparam int LSB_SUBMODE    = 4;
    localparam int LSB_MODE       = 6;

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [1:0] LOGIC_AND  = 2'h0;
    localparam logic [1:0] LOGIC_OR   = 2'h1;
    localparam logic [1:0] LOGIC_NOR  = 2'h2;
    localparam logic [1:0] LOGIC_NAND = 2'h3;

    localparam logic [1:0] EDGE_FALL  = 2'h0;
    localparam logic [1:0] EDGE_RISE  = 2'h1;
    localparam logic [1:0] EDGE_BOTH  = 2'h2;

    localparam logic [1:0] SUB_NORMAL   = 2'h0;
    localparam logic [1:0] SUB_PINGPONG = 2'h1;
    localparam logic [1:0] SUB_FORCE_LO = 2'h2;
    localparam logic [1:0] SUB_FORCE_HI = 2'h3;

    // Glitch filter length in cycles for each submode code, code 0 is no filter.
    localparam logic [3:0] GLITCH_LEN0 = 4'h0;
    localparam logic [3:0] GLITCH_LEN1 = 4'h2;
    localparam logic [3:0] GLITCH_LEN2 = 4'h4;
    localparam logic [3:0] GLITCH_LEN3 = 4'h8;

    // ------------------------------------------------------------------
    // Carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } tpcc_wbreq_s;

endpackage : tpcc_pkg

// file: rtl/tpcc_glitch_filter.sv
/*
 * Glitch filter with a three-flop input synchroniser.
 * Assumes the raw input is asynchronous to sys_clk; len is static while in use.
 */
`timescale 1ns/10ps
module tpcc_glitch_filter
    import tpcc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       rawIn,
    input  wire logic [3:0] len,
    output logic            filtOut
);
    logic [2:0] syncQ;
    logic [3:0] cntQ;
    logic       stableNew;

    // A change counts once the second and third stages agree.
    assign stableNew = (syncQ[1] == syncQ[2]) && (syncQ[2] != filtOut);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            syncQ   <= 3'h0;
            cntQ    <= 4'h0;
            filtOut <= 1'b0;
        end
        else
        begin
            syncQ <= {syncQ[1:0], rawIn};
            if (!stableNew)
                cntQ <= 4'h0;
            else if (cntQ >= len)
            begin
                filtOut <= syncQ[2];
                cntQ    <= 4'h0;
            end
            else
                cntQ <= cntQ + 4'h1;
        end
    end
endmodule : tpcc_glitch_filter

// file: rtl/tpcc_ctrl.sv
/*
 * Common control for the byte timer and word timer: mode, combined output pin,
 * submodes, demodulator input select, edge detection and falling-edge flag.
 * Assumes a classic Wishbone master on sys_clk and timer outputs from the same clock.
 */
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
module tpcc_ctrl
    import tpcc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        byteTimerOut,
    input  wire logic        wordTimerRaw,
    input  wire logic        portBitOut,
    input  wire logic        firstDemodInputPin,
    input  wire logic        secondDemodInputPin,
    output logic             combinedOutputPin,
    output logic             wordTimerOutput,
    output logic             demodMode,
    output logic             pingPongEn,
    output logic             pingPongStop,
    output logic             demodEdge,
    output logic             captureIrq2Src
);
    tpcc_wbreq_s req;
    logic [7:0]  ctrlQ;
    logic        flagQ;
    logic        filtPrevQ;
    logic        filtered;
    logic        demodIn;
    logic        isDemod;
    logic        hit;
    logic        wrStb;
    logic        rdStb;
    logic        sub0Write;
    logic [7:0]  ctrlD;
    logic [7:0]  readVal;
    logic [1:0]  logicSel;
    logic [1:0]  subSel;
    logic        combined;
    logic        wordNext;
    logic        riseEv;
    logic        fallEv;
    logic        edgeHit;
    logic [3:0]  glitchLen;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic combine(input logic [1:0] f, input logic a, input logic b);
        logic r;
        r = 1'b0;
        unique case (f)
            LOGIC_AND:  r = a & b;
            LOGIC_OR:   r = a | b;
            LOGIC_NOR:  r = ~(a | b);
            LOGIC_NAND: r = ~(a & b);
        endcase
        return r;
    endfunction : combine

    function automatic logic [3:0] glitch_of(input logic [1:0] s);
        logic [3:0] r;
        r = GLITCH_LEN0;
        unique case (s)
            2'h0: r = GLITCH_LEN0;
            2'h1: r = GLITCH_LEN1;
            2'h2: r = GLITCH_LEN2;
            2'h3: r = GLITCH_LEN3;
        endcase
        return r;
    endfunction : glitch_of

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    assign req       = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                         sel: wb_sel_i, dat: wb_dat_i};
    // Ack is held off for one cycle after each answer so a held request acts once.
    assign hit       = req.cyc && req.stb && !wb_ack_o && (req.adr == CTRL_ADDR);
    assign wrStb     = req.cyc && req.stb && !wb_ack_o && req.we && req.sel[0] && hit;
    assign rdStb     = req.cyc && req.stb && !wb_ack_o;
    assign isDemod   = (ctrlQ[LSB_MODE +: 2] != 2'h0);
    assign sub0Write = wrStb && req.dat[BIT_LEVEL_FLAG];

    // In signal_reception_mode mode bit 0 of the stored byte is not a level; a write never lands there.
    assign ctrlD     = isDemod ? {req.dat[7:1], ctrlQ[BIT_LEVEL_FLAG]} : req.dat[7:0];
    assign readVal   = isDemod ? {ctrlQ[7:1], flagQ} : ctrlQ;

    // ------------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------------
    assign logicSel  = ctrlQ[LSB_LOGIC +: 2];
    assign subSel    = ctrlQ[LSB_SUBMODE +: 2];
    assign wordNext  = (subSel == SUB_FORCE_LO) ? 1'b0 :
                       (subSel == SUB_FORCE_HI) ? 1'b1 : wordTimerRaw;
    assign combined  = combine(logicSel, byteTimerOut, wordTimerOutput);

    // ------------------------------------------------------------------
    // Signal_reception_mode path
    // ------------------------------------------------------------------
    // The second pin also feeds interrupt two; masking it is software's job.
    assign demodIn   = ctrlQ[BIT_SELECT] ? secondDemodInputPin : firstDemodInputPin;
    assign glitchLen = glitch_of(subSel);
    assign riseEv    = filtered && !filtPrevQ;
    assign fallEv    = !filtered && filtPrevQ;
    assign edgeHit   = (logicSel == EDGE_FALL) ? fallEv :
                       (logicSel == EDGE_RISE) ? riseEv :
                       (logicSel == EDGE_BOTH) ? (riseEv | fallEv) : 1'b0;

    tpcc_glitch_filter u_filter
    (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .rawIn   (demodIn),
        .len     (glitchLen),
        .filtOut (filtered)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrlQ    <= CTRL_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= rdStb;
            wb_dat_o <= (rdStb && hit && !req.we) ? {24'h00_0000, readVal} : 32'h0000_0000;
            if (wrStb)
                ctrlQ <= ctrlD;
        end
    end

    // The set wins over a clear arriving in the same cycle so no edge is lost.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            flagQ <= 1'b0;
        else if (isDemod && fallEv)
            flagQ <= 1'b1;
        else if (isDemod && sub0Write)
            flagQ <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            filtPrevQ         <= 1'b0;
            combinedOutputPin <= 1'b0;
            wordTimerOutput   <= 1'b0;
            demodMode         <= 1'b0;
            pingPongEn        <= 1'b0;
            pingPongStop      <= 1'b0;
            demodEdge         <= 1'b0;
            captureIrq2Src    <= 1'b0;
        end
        else
        begin
            filtPrevQ <= filtered;
            demodMode <= isDemod;
            if (wrStb && !isDemod && (req.dat[LSB_MODE +: 2] == 2'h0))
                wordTimerOutput <= req.dat[BIT_LEVEL_FLAG];
            else if (!isDemod)
                wordTimerOutput <= wordNext;
            combinedOutputPin <= (!isDemod && ctrlQ[BIT_SELECT]) ? combined : portBitOut;
            pingPongEn        <= !isDemod && (subSel == SUB_PINGPONG);
            pingPongStop      <= wrStb && !isDemod
                                 && (req.dat[LSB_SUBMODE +: 2] == SUB_NORMAL);
            demodEdge         <= isDemod && edgeHit;
            captureIrq2Src    <= isDemod && ctrlQ[BIT_SELECT] && edgeHit;
        end
    end

endmodule : tpcc_ctrl

// file: test/tpcc_ctrl_chk.sv
/* Port assertions for the timer pair common control block.
   Bound from the testbench top file; it watches the block's ports only. */
`timescale 1ns/10ps
module tpcc_ctrl_chk
    import tpcc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        demodMode,
    input wire logic        pingPongEn,
    input wire logic        pingPongStop,
    input wire logic        demodEdge,
    input wire logic        captureIrq2Src
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i != CTRL_ADDR
        |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
    AST_MODE: assert property (wb_ack_o && !wb_we_i && wb_adr_i == CTRL_ADDR
        |-> demodMode == (wb_dat_o[7:6] != 2'h0)) else $error("mode output wrong");
    AST_PP_TX: assert property (pingPongEn |-> !demodMode)
        else $error("alternating_timer_operation in signal_reception_mode");
    AST_STOP_ONE: assert property (pingPongStop |=> !pingPongStop)
        else $error("stop pulse too long");
    AST_EDGE_DEMOD: assert property (demodEdge |-> demodMode)
        else $error("edge outside signal_reception_mode");
    AST_INTERRUPT_REQUEST_TWO: assert property (captureIrq2Src |-> demodEdge && demodMode)
        else $error("interrupt two source without edge");
endmodule : tpcc_ctrl_chk

// file: test/tpcc_pin_model.sv
/* Pin model: demodulator inputs idling high, timer outputs and the port bit.
   The testbench calls its tasks; every change lands just after a rising edge. */
`timescale 1ns/10ps
module tpcc_pin_model
(
    input  wire logic sys_clk,
    output logic      firstDemodInputPin,
    output logic      secondDemodInputPin,
    output logic      byteTimerOut,
    output logic      wordTimerRaw,
    output logic      portBitOut
);
    initial {secondDemodInputPin, firstDemodInputPin} = 2'h3;
    initial {byteTimerOut, wordTimerRaw, portBitOut} = 3'h0;
    task automatic setTimers(input logic [2:0] v);
        @(posedge sys_clk);
        {byteTimerOut, wordTimerRaw, portBitOut} <= v;
    endtask : setTimers
    // A low pulse on one pin; on the second pin it may also raise interrupt two.
    task automatic pulse(input logic second, input int width);
        @(posedge sys_clk);
        {secondDemodInputPin, firstDemodInputPin} <= second ? 2'h1 : 2'h2;
        repeat (width) @(posedge sys_clk);
        {secondDemodInputPin, firstDemodInputPin} <= 2'h3;
    endtask : pulse
endmodule : tpcc_pin_model

// file: test/tb.sv
/* Self-checking bench for tpcc_ctrl: a Wishbone master task and scenario tasks.
   Assumes tpcc_pin_model for the pins; binds tpcc_ctrl_chk to the block. */
`timescale 1ns/10ps
module tb
    import tpcc_pkg::*;
();
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, byteTimerOut, wordTimerRaw, portBitOut, firstDemodInputPin;
    logic        secondDemodInputPin, combinedOutputPin, wordTimerOutput, demodMode;
    logic        pingPongEn, pingPongStop, demodEdge, captureIrq2Src;
    int          fail_count = 0, n_checks = 0, edgeCnt = 0, irqCnt = 0, stopCnt = 0;
    always #5 sys_clk = ~sys_clk;
    // Pulse outputs are counted so a scenario can judge what a stimulus caused.
    always @(posedge sys_clk)
    begin
        edgeCnt <= edgeCnt + int'(demodEdge === 1'b1);
        irqCnt <= irqCnt + int'(captureIrq2Src === 1'b1);
        stopCnt <= stopCnt + int'(pingPongStop === 1'b1);
    end
    tpcc_ctrl i_dut (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .byteTimerOut, .wordTimerRaw, .portBitOut,
        .firstDemodInputPin, .secondDemodInputPin, .combinedOutputPin, .wordTimerOutput,
        .demodMode, .pingPongEn, .pingPongStop, .demodEdge, .captureIrq2Src);
    tpcc_pin_model i_pins (.sys_clk, .firstDemodInputPin, .secondDemodInputPin,
        .byteTimerOut, .wordTimerRaw, .portBitOut);
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d,
                      output logic [31:0] q);
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'h3, we, adr, 4'h1};
        wb_dat_i <= {24'h00_0000, d};
        // No cycle count is assumed here; only the watchdog ends a wait that never ends.
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask : wb
    task automatic wr(input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, CTRL_ADDR, d, q);
    endtask : wr
    task automatic testTransmit();
        logic [31:0] q;
        int s;
        wb(1'b0, CTRL_ADDR, 8'h00, q);
        chk("reset", q, {24'h00_0000, CTRL_RESET});
        wb(1'b1, 8'h08, 8'hff, q);
        wb(1'b0, 8'h08, 8'h00, q);
        chk("unmapped", q, 32'h0000_0000);
        wr(8'h01);
        chk("initLevel", wordTimerOutput, 1'b1);
        wb(1'b0, CTRL_ADDR, 8'h00, q);
        chk("level", q, 32'h0000_0001);
        i_pins.setTimers(3'h7);
        wr(8'h20);
        repeat (4) @(posedge sys_clk);
        chk("forceLow", wordTimerOutput, 1'b0);
        i_pins.setTimers(3'h1);
        wr(8'h30);
        repeat (4) @(posedge sys_clk);
        chk("forceHigh", wordTimerOutput, 1'b1);
        chk("portPin", combinedOutputPin, 1'b1);
        wr(8'h10);
        repeat (2) @(posedge sys_clk);
        chk("ppOn", pingPongEn, 1'b1);
        s = stopCnt;
        wr(8'h00);
        repeat (3) @(posedge sys_clk);
        chk("ppOff", pingPongEn, 1'b0);
        chk("ppStop", stopCnt - s, 1);
    endtask : testTransmit
    task automatic testLogic();
        logic e;
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h02 | 8'(c << 2));
            for (int v = 0; v < 4; v++)
            begin
                i_pins.setTimers({v[1:0], 1'b0});
                repeat (4) @(posedge sys_clk);
                e = c == 0 ? &v[1:0] : c == 1 ? |v[1:0] : c == 2 ? ~|v[1:0] : ~&v[1:0];
                chk("combined", combinedOutputPin, e);
            end
        end
    endtask : testLogic
    task automatic testDemod();
        logic [31:0] q;
        int e, s;
        wr(8'hc0);
        repeat (2) @(posedge sys_clk);
        chk("demod", demodMode, 1'b1);
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h40 | 8'(c << 2));
            e = edgeCnt;
            i_pins.pulse(1'b0, 10);
            chk("edgeEarly", edgeCnt - e, c == 0 || c == 2);
            repeat (20) @(posedge sys_clk);
            chk("edgeLate", edgeCnt - e, c == 3 ? 0 : c == 2 ? 2 : 1);
        end
        wr(8'h40);
        wb(1'b0, CTRL_ADDR, 8'h00, q);
        chk("flagKept", q, 32'h0000_0041);
        wr(8'h41);
        wb(1'b0, CTRL_ADDR, 8'h00, q);
        chk("flagClr", q, 32'h0000_0040);
        wr(8'h42);
        {e, s} = {edgeCnt, irqCnt};
        i_pins.pulse(1'b0, 10);
        i_pins.pulse(1'b1, 10);
        repeat (20) @(posedge sys_clk);
        chk("second", edgeCnt - e, 1);
        chk("interrupt_request_two", irqCnt - s, 1);
        wr(8'h70);
        e = edgeCnt;
        i_pins.pulse(1'b0, 3);
        repeat (20) @(posedge sys_clk);
        chk("glitch", edgeCnt - e, 0);
        i_pins.pulse(1'b0, 16);
        repeat (20) @(posedge sys_clk);
        chk("wide", edgeCnt - e, 1);
    endtask : testDemod
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        testTransmit();
        testLogic();
        testDemod();
        test_done();
    end
    // The scenarios need about four hundred cycles; twenty-five times that means a hang.
    initial
    begin
        repeat (10000) @(posedge sys_clk);
        fail_count++;
        test_done();
    end
endmodule : tb
bind tpcc_ctrl tpcc_ctrl_chk i_chk (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .demodMode, .pingPongEn, .pingPongStop, .demodEdge,
    .captureIrq2Src);
